//--- power_mode_pkg.sv
// Constants and types shared by the power mode controller
// Function
// (RQ1) Setting idle select halts the CPU once the setting instruction completes.
// (RQ2) Idle keeps registers, memory, clocks and peripherals running.
// (RQ3) Idle ends on any enabled interrupt or any reset.
// (RQ4) Interrupt wake clears idle select, resumes CPU, services interrupt, then continues.
// (RQ5) Reset ending idle or stop runs reset sequence, fetches from zero.
// (RQ6) Enabled supervisory timer keeps running in idle and may reset out.
// (RQ7) Software may disable the supervisory timer before idle to sleep indefinitely.
// (RQ8) Software follows the idle-setting instruction with a multi-byte instruction.
// (RQ9) Setting stop select enters stop once the setting instruction completes.
// (RQ10) Stop halts internal oscillator, CPU, digital peripherals; external oscillator untouched.
// (RQ11) In stop, interrupts and timers inactive, clock halted, analog enables held.
// (RQ12) Only a reset leaves stop; interrupts never wake it.
// (RQ13) Missing clock detector stays active in stop and resets after timeout.
// (RQ14) With oscillators off, only reset restarts the core.
// (RQ15) Idle and stop select bits always read back as zero.
// (RQ16) Upper six bits are plain read/write general flags, reset zero.
package power_mode_pkg;
    localparam logic [7:0] power_control_addr = 8'h87;
    localparam logic [7:0] power_control_reset = 8'h00;
    localparam int idle_bit = 0;
    localparam int stop_bit = 1;
    localparam int flags_lsb = 2;
    localparam int flags_width = 6;
    localparam logic [15:0] restart_vector = 16'h0000;
    localparam int clock_loss_timeout_us = 100;
    localparam int clock_mhz = 250;
    localparam int clock_loss_timeout_cycles = clock_loss_timeout_us * clock_mhz;

    typedef enum logic [2:0] {
        run_state = 3'b001,
        idle_state = 3'b010,
        stop_state = 3'b100
    } mode_type;

    typedef struct packed {
        logic write;
        logic read;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic insn_done;
    } sfr_req_type;

    typedef struct packed {
        logic cpu_clock_en;
        logic periph_clock_en;
        logic int_osc_en;
        logic irq_enable;
    } gate_type;
endpackage

//--- power_mode_flags.sv
// General purpose flag storage of the power control register
`timescale 1ns/10ps
`default_nettype none
module power_mode_flags
    import power_mode_pkg::*;
#(
    parameter int width = flags_width
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic load,
    input wire logic [width-1:0] wdata,
    output logic [width-1:0] flags_q
);
    always_ff @(posedge mclk) begin
        if (reset) begin
            flags_q <= power_control_reset[flags_lsb +: width]; // RQ16
        end else if (load) begin
            flags_q <= wdata; // RQ16
        end
    end
endmodule
`default_nettype wire

//--- power_mode_control.sv
// Idle and stop power mode controller with its control register
`timescale 1ns/10ps
`default_nettype none
module power_mode_control
    import power_mode_pkg::*;
#(
    parameter int clock_loss_cycles = clock_loss_timeout_cycles
) (
    input wire logic mclk,
    input wire logic reset,
    input wire sfr_req_type sfr_req,
    input wire logic irq_pending,
    input wire logic supervisory_timer_en,
    input wire logic supervisory_timer_expired,
    input wire logic missing_clock_detector_en,
    output logic [7:0] sfr_rdata_q,
    output logic sfr_rvalid_q,
    output gate_type gates_q,
    output logic cpu_halt_q,
    output logic irq_service_q,
    output logic [15:0] fetch_addr_q,
    output logic fetch_load_q,
    output logic internal_reset_q,
    output logic [1:0] mode_q
);
    mode_type state_q;
    mode_type state_d;
    logic idle_arm_q;
    logic stop_arm_q;
    logic [flags_width-1:0] flags;
    logic [31:0] loss_count_q;
    logic loss_fire_q;

    // Decode of the control register
    wire reg_hit = sfr_req.addr == power_control_addr;
    wire reg_write = sfr_req.write && reg_hit;
    wire reg_read = sfr_req.read && reg_hit;
    wire set_idle = reg_write && sfr_req.wdata[idle_bit];
    wire set_stop = reg_write && sfr_req.wdata[stop_bit];

    // Reset sources that end idle or stop; the timer keeps counting in idle
    wire timer_reset = supervisory_timer_en && supervisory_timer_expired; // RQ6
    wire loss_armed = missing_clock_detector_en && state_q == stop_state; // RQ13
    wire loss_at_limit = loss_count_q == 32'(clock_loss_cycles - 1);
    wire any_reset = timer_reset || loss_fire_q;

    // A select bit written by the completing instruction counts at once
    wire idle_pending = idle_arm_q || set_idle;
    wire stop_pending = stop_arm_q || set_stop;
    wire go_idle = idle_pending && sfr_req.insn_done; // RQ1
    wire go_stop = stop_pending && sfr_req.insn_done; // RQ9
    wire idle_wake = state_q == idle_state && irq_pending; // RQ3
    wire arm_clear = any_reset || go_idle || go_stop;

    // Next values of the registered outputs
    wire next_run = state_d == run_state;
    wire next_idle = state_d == idle_state;
    wire next_stop = state_d == stop_state;
    wire [7:0] read_value = {flags, 2'b00}; // RQ15
    wire [7:0] rdata_d = reg_read ? read_value : 8'h00; // RQ16
    wire service_d = idle_wake && !any_reset; // RQ4
    wire cpu_clock_d = next_run; // RQ1
    wire periph_clock_d = !next_stop; // RQ2 RQ10
    wire int_osc_d = !next_stop; // RQ10 RQ14
    wire irq_enable_d = !next_stop; // RQ11
    wire gate_type gates_d = {cpu_clock_d, periph_clock_d, int_osc_d, irq_enable_d};
    wire [1:0] mode_d = {next_stop, next_idle};

    power_mode_flags #(
        .width(flags_width)
    ) flag_store (
        .mclk(mclk),
        .reset(reset),
        .load(reg_write),
        .wdata(sfr_req.wdata[flags_lsb +: flags_width]),
        .flags_q(flags)
    );

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            run_state: begin
                if (go_stop) begin
                    state_d = stop_state; // RQ9
                end else if (go_idle) begin
                    state_d = idle_state; // RQ1
                end
            end
            idle_state: begin
                if (idle_wake) begin
                    state_d = run_state; // RQ3
                end
            end
            stop_state: begin
                // Interrupts are ignored here; only reset leaves stop
                state_d = stop_state; // RQ11 RQ12
            end
            default: state_d = run_state;
        endcase
        // An internal reset returns to run, so state and outputs agree
        if (any_reset) begin
            state_d = run_state; // RQ5 RQ14
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_q <= run_state; // RQ5
        end else begin
            state_q <= state_d;
        end
    end

    // Select bits arm until the writing instruction completes
    always_ff @(posedge mclk) begin
        if (reset || arm_clear) begin
            idle_arm_q <= 1'b0; // RQ4
        end else if (set_idle) begin
            idle_arm_q <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset || arm_clear) begin
            stop_arm_q <= 1'b0;
        end else if (set_stop) begin
            stop_arm_q <= 1'b1;
        end
    end

    // Missing clock detector timeout, counted only during stop
    always_ff @(posedge mclk) begin
        if (reset || !loss_armed || loss_fire_q) begin
            loss_count_q <= 32'h0;
        end else if (!loss_at_limit) begin
            loss_count_q <= loss_count_q + 32'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset || !loss_armed || loss_fire_q) begin
            loss_fire_q <= 1'b0;
        end else if (loss_at_limit) begin
            loss_fire_q <= 1'b1; // RQ13
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            sfr_rdata_q <= 8'h00;
        end else begin
            sfr_rdata_q <= rdata_d; // RQ15 RQ16
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            sfr_rvalid_q <= 1'b0;
        end else begin
            sfr_rvalid_q <= reg_read;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            gates_q <= '{1'b1, 1'b1, 1'b1, 1'b1};
        end else begin
            gates_q <= gates_d; // RQ2 RQ10 RQ11
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            cpu_halt_q <= 1'b0;
        end else begin
            cpu_halt_q <= !next_run; // RQ1
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            irq_service_q <= 1'b0;
        end else begin
            irq_service_q <= service_d; // RQ4
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            fetch_addr_q <= restart_vector;
        end else begin
            fetch_addr_q <= restart_vector; // RQ5
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            fetch_load_q <= 1'b1;
        end else begin
            fetch_load_q <= any_reset; // RQ5
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            internal_reset_q <= 1'b0;
        end else begin
            internal_reset_q <= any_reset; // RQ6 RQ13
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            mode_q <= 2'b00;
        end else begin
            mode_q <= mode_d;
        end
    end
endmodule
`default_nettype wire

//--- power_mode_control_sva.sv
// Assertions for the power mode controller
`timescale 1ns/10ps
`default_nettype none
module power_mode_control_sva
    import power_mode_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire sfr_req_type sfr_req,
    input wire logic irq_pending,
    input wire logic supervisory_timer_en,
    input wire logic supervisory_timer_expired,
    input wire logic missing_clock_detector_en,
    input wire logic [7:0] sfr_rdata_q,
    input wire logic sfr_rvalid_q,
    input wire gate_type gates_q,
    input wire logic cpu_halt_q,
    input wire logic irq_service_q,
    input wire logic internal_reset_q,
    input wire logic [1:0] mode_q
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    wire logic wd = supervisory_timer_en & supervisory_timer_expired;
    wire logic sel = sfr_req.addr == power_control_addr;
    a_read_answer: assert property (sfr_req.read && sel |=> sfr_rvalid_q)
        else $error("read not answered");
    a_select_zero: assert property (sfr_rvalid_q |-> sfr_rdata_q[1:0] == 2'b00)
        else $error("select bits not zero");
    a_idle_entry: assert property (mode_q == 2'b00 && sfr_req.write && sel &&
        sfr_req.wdata[1:0] == 2'b01 && sfr_req.insn_done && !wd |=> mode_q == 2'b01)
        else $error("idle not entered");
    a_stop_entry: assert property (mode_q == 2'b00 && sfr_req.write && sel &&
        sfr_req.wdata[1] && sfr_req.insn_done && !wd |=> mode_q == 2'b10)
        else $error("stop not entered");
    a_idle_gates: assert property (mode_q == 2'b01 |-> cpu_halt_q && gates_q == 4'b0111)
        else $error("idle gating wrong");
    a_irq_wake: assert property (mode_q == 2'b01 && irq_pending && !wd
        |=> mode_q == 2'b00 && irq_service_q)
        else $error("no interrupt wake");
    a_stop_hold: assert property (mode_q == 2'b10 && !missing_clock_detector_en && !wd
        |=> mode_q == 2'b10)
        else $error("stop left without reset");
    a_stop_gates: assert property (mode_q == 2'b10 |-> cpu_halt_q && gates_q == 4'b0000)
        else $error("stop gating wrong");
    a_timer_reset: assert property (wd |=> internal_reset_q && mode_q == 2'b00)
        else $error("no timer reset");
endmodule
bind power_mode_control power_mode_control_sva power_mode_control_sva_i (.*);
`default_nettype wire

//--- test_power_mode_control.sv
// Randomised self-checking bench for the power mode controller
`timescale 1ns/10ps
`default_nettype none
module test_power_mode_control;
    import power_mode_pkg::*;
    logic mclk = 0, reset = 1, irq_pending = 0, missing_clock_detector_en = 0;
    logic supervisory_timer_en = 0, supervisory_timer_expired = 0;
    sfr_req_type sfr_req = '0;
    logic [7:0] sfr_rdata_q, f;
    logic sfr_rvalid_q, cpu_halt_q, irq_service_q, fetch_load_q, internal_reset_q;
    gate_type gates_q;
    logic [15:0] fetch_addr_q;
    logic [1:0] mode_q;
    int err_count = 0, checked = 0, cyc = 0, n = 0;
    localparam int loss_cycles = 20;
    always #2 mclk = ~mclk;
    power_mode_control #(.clock_loss_cycles(loss_cycles)) power_mode_control_i (.*);
    task automatic end_of_test();
        if (err_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic op(input logic w, input logic r, input logic [7:0] d, input logic done);
        @(negedge mclk);
        sfr_req = {w, r, 8'h87, d, done};
        @(negedge mclk);
        sfr_req = '0;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            end_of_test();
        end
    end
    initial begin
        void'($urandom(32'h5e0271d5));
        repeat (4) @(negedge mclk);
        reset = 0;
        op(0, 1, 8'h00, 0);
        chk({7'h00, sfr_rvalid_q, sfr_rdata_q}, 16'h0100);
        repeat (8) begin
            f = 8'($urandom) & 8'hfc;
            op(1, 0, f, 0);
            op(0, 1, 8'h00, 0);
            chk({7'h00, sfr_rvalid_q, sfr_rdata_q}, {8'h01, f});
        end
        op(1, 0, f | 8'h01, 0);
        op(0, 0, 8'h00, 1);
        repeat (5) @(negedge mclk);
        chk({cpu_halt_q, gates_q, 9'h0, mode_q}, 16'hb801);
        irq_pending = 1;
        @(negedge mclk);
        irq_pending = 0;
        chk({irq_service_q, 13'h0, mode_q}, 16'h8000);
        op(0, 1, 8'h00, 0);
        chk({7'h00, sfr_rvalid_q, sfr_rdata_q}, {8'h01, f});
        missing_clock_detector_en = 1;
        op(1, 0, 8'h03, 1);
        irq_pending = 1;
        repeat (3) @(negedge mclk);
        irq_pending = 0;
        chk({gates_q, 10'h0, mode_q}, 16'h0002);
        n = 3;
        while (internal_reset_q !== 1'b1 && n < 40) begin
            @(negedge mclk);
            n++;
        end
        chk(16'(n), 16'(loss_cycles + 1));
        chk({internal_reset_q, 13'h0, mode_q}, 16'h8000);
        chk(fetch_addr_q, 16'h0000);
        chk({15'h0, fetch_load_q}, 16'h0001);
        missing_clock_detector_en = 0;
        op(1, 0, 8'h01, 1);
        supervisory_timer_expired = 1;
        @(negedge mclk);
        chk({14'h0, mode_q}, 16'h0001);
        supervisory_timer_en = 1;
        @(negedge mclk);
        supervisory_timer_expired = 0;
        chk({internal_reset_q, 13'h0, mode_q}, 16'h8000);
        op(1, 0, 8'hff, 1);
        irq_pending = 1;
        @(negedge mclk);
        irq_pending = 0;
        chk({14'h0, mode_q}, 16'h0002);
        reset = 1;
        @(negedge mclk);
        reset = 0;
        chk({fetch_load_q, 13'h0, mode_q}, 16'h8000);
        op(0, 1, 8'h00, 0);
        chk({7'h00, sfr_rvalid_q, sfr_rdata_q}, 16'h0100);
        end_of_test();
    end
endmodule
`default_nettype wire
